// ### dv/i2c_host_model.sv
// Two-wire bus master that stands in for the host controller.
// Assumes an external pull-up: sda_line is the wired level of the pin.
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF = 6 // Cycles per clock phase, above the 4 required
) (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // Bus idles released: clock driven high, data high through the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Every change lands on a falling edge, one phase apart
  task automatic hold();
    repeat (HALF) @(negedge clk_sys);
  endtask
  // Also serves as repeated start: data rises while the clock is low
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 0;
    hold();
  endtask
  // Data is set a full phase after the clock fall, so the slave never
  // sees it move while the clock is high
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda_line;
    scl = 1'b0;
    hold();
  endtask
  // Most significant bit first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Line is released for the slave; ack chooses whether reading goes on
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!ack, r);
  endtask
endmodule // i2c_host_model

// ### dv/tb.sv
// Self-checking bench for the charger control register bank.
// Assumes the host model in dv/ and the design sources under hdl/.
`timescale 1ns/1ps
`include "charger_regs.svh"
module tb
  import charger_pkg::*;
;
  logic clk_sys, rst_n, src_sel_pin, charge_enable_n_pin, kick_seen, ok;
  logic [3:0] ev; // Event pulses: expire, cleared, reset, detect
  logic scl, sda_low, sda_out, sda_oe;
  logic input_disconnect_en, high_impedance_state, status_pin_en;
  logic light_load_mode_off, watchdog_kick, boost_output_en, charge_en_bit;
  logic charge_active, boost_low_batt_sel, boost_current_limit;
  logic input_switch_full_on, high_r_switch_sel;
  logic [1:0] status_pin_ctrl;
  logic [2:0] min_system_voltage;
  logic [4:0] input_current_limit;
  logic [5:0] fast_charge_current;
  logic [11:0] batt_low_fall_mv, batt_low_rise_mv;
  logic [31:0] v;
  int bad_count, comparisons;
  wire sda_line;
  // Open-drain wire: low if either party pulls, else the pull-up wins
  assign sda_line = !(sda_low || (sda_oe && !sda_out));
  ////////////////////////////////////////////////////////////////////////
  charger_ctrl_regs dut_u (
    .clk_sys, .rst_n, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .src_sel_pin, .charge_enable_n_pin, .wd_expire(ev[0]),
    .wd_timer_cleared(ev[1]), .reg_reset(ev[2]), .src_detect_done(ev[3]),
    .input_disconnect_en, .high_impedance_state, .status_pin_ctrl,
    .status_pin_en, .input_current_limit, .light_load_mode_off,
    .watchdog_kick, .boost_output_en, .charge_en_bit, .charge_active,
    .min_system_voltage, .boost_low_batt_sel, .batt_low_fall_mv,
    .batt_low_rise_mv, .boost_current_limit, .input_switch_full_on,
    .high_r_switch_sel, .fast_charge_current
  );
  i2c_host_model host_u (.clk_sys, .sda_line, .scl, .sda_low);
  // Clock at 50 MHz
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Kick is a one-cycle pulse, so it is caught by a sticky flag
  always @(posedge clk_sys) if (watchdog_kick === 1'b1) kick_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic pulse(input int k);
    @(negedge clk_sys) ev[k] = 1'b1;
    @(negedge clk_sys) ev[k] = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Write n bytes of d, first byte highest; ok only if all were acked
  task automatic wr(input logic [6:0] dev, input byte_t a, input int n,
      input logic [31:0] d);
    logic ak;
    host_u.start();
    host_u.wbyte({dev, 1'b0}, ak);
    ok = ak;
    host_u.wbyte(a, ak);
    ok = ok & ak;
    for (int i = n - 1; i >= 0; i--) begin
      host_u.wbyte(d[8*i +: 8], ak);
      ok = ok & ak;
    end
    host_u.stop();
  endtask
  // Read n bytes through a repeated start, packed first byte highest
  task automatic rd(input byte_t a, input int n);
    logic ak;
    byte_t b;
    v = 32'h0;
    host_u.start();
    host_u.wbyte({`DEV_ADDR, 1'b0}, ak);
    host_u.wbyte(a, ak);
    host_u.start();
    host_u.wbyte({`DEV_ADDR, 1'b1}, ak);
    for (int i = 0; i < n; i++) begin
      host_u.rbyte(i < n - 1, b);
      v = {v[23:0], b};
    end
    host_u.stop();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h00, 3);
    chk(v, 32'h171aa2, "power-on values");
    chk({input_disconnect_en, status_pin_en, input_current_limit}, 7'h37,
        "input fields");
    chk({light_load_mode_off, boost_output_en, charge_en_bit,
        min_system_voltage}, 6'h0d, "config fields");
    chk({batt_low_fall_mv, batt_low_rise_mv}, 24'hb86c4e, "low batt");
    chk({boost_current_limit, high_r_switch_sel, fast_charge_current},
        8'ha2, "current fields");
    chk(charge_active, 1'b0, "charge with pin high");
    $display("test reset values done");
  endtask
  // Limit is locked until detection, then loaded from the select pin
  task automatic t_detect();
    wr(`DEV_ADDR, 8'h00, 1, 32'he3);
    chk(ok, 1'b1, "write acked");
    rd(8'h00, 1);
    chk(v, 32'hf7, "limit locked");
    chk({high_impedance_state, status_pin_en}, 2'b10, "pin fields");
    pulse(3);
    rd(8'h00, 1);
    chk(v, 32'he4, "detected limit");
    wr(`DEV_ADDR, 8'h00, 1, 32'he5);
    chk(high_r_switch_sel, 1'b1, "switch below 700");
    wr(`DEV_ADDR, 8'h00, 1, 32'he6);
    chk(high_r_switch_sel, 1'b0, "switch at 700");
    $display("test detection done");
  endtask
  task automatic t_charge();
    @(negedge clk_sys) charge_enable_n_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(charge_active, 1'b1, "charge on");
    wr(`DEV_ADDR, 8'h01, 2, 32'h3a7f);
    chk({charge_active, boost_output_en}, 2'b01, "boost wins");
    rd(8'h01, 2);
    chk(v, 32'h3a72, "clamped current");
    wr(`DEV_ADDR, 8'h01, 2, 32'h1a00);
    chk(charge_active, 1'b0, "zero current");
    wr(`DEV_ADDR, 8'h02, 1, 32'h22);
    chk(charge_active, 1'b1, "charge back on");
    wr(`DEV_ADDR, 8'h01, 1, 32'h0a);
    chk(charge_active, 1'b0, "enable bit off");
    $display("test charge gating done");
  endtask
  // Wrong slave, bad address, running past the end, the skipped fault reg
  task automatic t_refuse();
    wr(7'h6a, 8'h00, 1, 32'h00);
    chk(ok, 1'b0, "other slave");
    wr(`DEV_ADDR, 8'h0c, 1, 32'h00);
    chk(ok, 1'b0, "undefined reg");
    rd(8'h00, 1);
    chk(v, 32'he6, "nothing written");
    wr(`DEV_ADDR, 8'h08, 4, 32'h0);
    chk(ok, 1'b0, "fourth byte past end");
    rd(8'h08, 4);
    chk(v, 32'h0000_00ff, "skip and past end");
    $display("test refusals done");
  endtask
  task automatic t_kick();
    kick_seen = 1'b0;
    wr(`DEV_ADDR, 8'h01, 1, 32'h5a);
    chk(kick_seen, 1'b1, "kick pulse");
    rd(8'h01, 1);
    chk(v, 32'h5a, "kick held");
    pulse(1);
    rd(8'h01, 1);
    chk(v, 32'h1a, "kick cleared");
    kick_seen = 1'b0;
    wr(`DEV_ADDR, 8'h01, 1, 32'h1a);
    chk(kick_seen, 1'b0, "zero kick");
    $display("test watchdog kick done");
  endtask
  // Expiry restores only its own fields; register reset restores all
  task automatic t_restore();
    wr(`DEV_ADDR, 8'h01, 2, 32'hbe41);
    pulse(0);
    rd(8'h00, 3);
    chk(v, 32'h669ee2, "expiry restore");
    pulse(2);
    rd(8'h00, 3);
    chk(v, 32'h171aa2, "register reset");
    $display("test restore done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ev = 4'h0;
    src_sel_pin = 1'b1;
    charge_enable_n_pin = 1'b1;
    kick_seen = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    t_reset();
    t_detect();
    t_charge();
    t_refuse();
    t_kick();
    t_restore();
    conclude();
  end
  // The tests take some 17k cycles; a hang ends the run here
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    $display("BAD %0t timeout", $time);
    conclude();
  end
endmodule // tb

// ### hdl/charger_ctrl_regs.sv
// Charger control registers 0x00-0x02 behind a serial two-wire slave.
// Assumes watchdog, detection and reset pulses come from clk_sys logic.
`timescale 1ns/1ps
`include "charger_regs.svh"
module charger_ctrl_regs
  import charger_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `DEV_ADDR,
  parameter logic [4:0] IIN_CODE_SRC_LOW = 5'h17,
  parameter logic [11:0] ALT_FALL_MV = `LOW_BATT_FALL_MV,
  parameter logic [11:0] ALT_RISE_MV = `LOW_BATT_RISE_MV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic src_sel_pin,
  input wire logic charge_enable_n_pin,
  input wire logic wd_expire,
  input wire logic wd_timer_cleared,
  input wire logic reg_reset,
  input wire logic src_detect_done,
  output logic input_disconnect_en,
  output logic high_impedance_state,
  output logic [1:0] status_pin_ctrl,
  output logic status_pin_en,
  output logic [4:0] input_current_limit,
  output logic light_load_mode_off,
  output logic watchdog_kick,
  output logic boost_output_en,
  output logic charge_en_bit,
  output logic charge_active,
  output logic [2:0] min_system_voltage,
  output logic boost_low_batt_sel,
  output logic [11:0] batt_low_fall_mv,
  output logic [11:0] batt_low_rise_mv,
  output logic boost_current_limit,
  output logic input_switch_full_on,
  output logic high_r_switch_sel,
  output logic [5:0] fast_charge_current
);

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling
  logic scl_s, sda_s, src_sel_s, ce_n_s; // Synchronised pins
  logic scl_p_q, sda_p_q; // Previous synchronised bus levels
  sync_2ff #(.RESET_VAL(1'b1)) u_sync_scl (.clk_sys(clk_sys),
    .rst_n(rst_n), .async_in(scl_in), .sync_out(scl_s));
  sync_2ff #(.RESET_VAL(1'b1)) u_sync_sda (.clk_sys(clk_sys),
    .rst_n(rst_n), .async_in(sda_in), .sync_out(sda_s));
  sync_2ff #(.RESET_VAL(1'b0)) u_sync_sel (.clk_sys(clk_sys),
    .rst_n(rst_n), .async_in(src_sel_pin), .sync_out(src_sel_s));
  // Pin defaults high so charging stays off until the pin is first sampled
  sync_2ff #(.RESET_VAL(1'b1)) u_sync_ce (.clk_sys(clk_sys),
    .rst_n(rst_n), .async_in(charge_enable_n_pin), .sync_out(ce_n_s));

  // Edge history, read only after the second synchroniser stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // Data edges while the clock stays high frame a transfer
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  byte_t regs_q [3]; // Eight-bit registers
  byte_t regs_d [3];
  logic det_done_q, det_done_d; // Source detection has completed
  logic kick_q, kick_d; // Pulse toward the watchdog timer
  byte_t rd_data; // Byte presented for a read
  logic wr_en; // Byte received for a register
  byte_t wr_data;
  byte_t ptr_q, ptr_d; // Register pointer
  byte_t ptr_next; // Pointer after auto-increment

  // Auto-increment steps over the fault register
  assign ptr_next = (ptr_q == `OFS_FAULT - 8'h01) ? `OFS_AFTER_FAULT :
                    ptr_q + 8'h01;

  // Read mux: held registers, other mapped ones zero, beyond 0x0b ones
  always_comb begin
    if (ptr_q > `OFS_LAST) begin
      rd_data = `RD_UNMAPPED;
    end else if (ptr_q <= `OFS_CHARGE_CURRENT_CONTROL) begin
      rd_data = regs_q[ptr_q[1:0]];
    end else begin
      rd_data = `RD_NOT_HELD;
    end
  end

  // Next register values; later steps take priority
  always_comb begin
    regs_d = regs_q;
    det_done_d = det_done_q | src_detect_done;
    kick_d = 1'b0;
    // Watchdog expiry restores only its own fields
    if (wd_expire) begin
      regs_d[0] = (regs_q[0] & ~`WD_MASK_INPUT_CONTROL) |
                  (`POR_INPUT_CONTROL & `WD_MASK_INPUT_CONTROL);
      regs_d[1] = (regs_q[1] & ~`WD_MASK_POWER_ON_CONFIG) |
                  (`POR_POWER_ON_CONFIG & `WD_MASK_POWER_ON_CONFIG);
      regs_d[2] = (regs_q[2] & ~`WD_MASK_CHARGE_CURRENT_CONTROL) |
                  (`POR_CHARGE_CURRENT_CONTROL &
                   `WD_MASK_CHARGE_CURRENT_CONTROL);
    end
    // Timer has restarted, so drop the kick request
    if (wd_timer_cleared) begin
      regs_d[1][`BIT_KICK] = 1'b0;
    end
    // Detection result replaces the input limit
    if (src_detect_done) begin
      regs_d[0][4:0] = src_sel_s ? `IIN_CODE_500MA : IIN_CODE_SRC_LOW;
    end
    // Host writes come after hardware clears, so a set wins
    if (wr_en) begin
      unique case (ptr_q)
        `OFS_INPUT_CONTROL: begin
          regs_d[0][7:5] = wr_data[7:5];
          // Limit is locked until detection has finished
          if (det_done_q) begin
            regs_d[0][4:0] = wr_data[4:0];
          end
        end
        `OFS_POWER_ON_CONFIG: begin
          regs_d[1][7] = wr_data[7];
          regs_d[1][5:0] = wr_data[5:0];
          // Only a one does anything on the kick bit
          if (wr_data[`BIT_KICK]) begin
            regs_d[1][`BIT_KICK] = 1'b1;
            kick_d = 1'b1;
          end
        end
        `OFS_CHARGE_CURRENT_CONTROL: begin
          regs_d[2][7:6] = wr_data[7:6];
          // Oversized codes are stored as the ceiling
          regs_d[2][5:0] = (wr_data[5:0] > `FAST_CHARGE_CURRENT_CODE_MAX) ?
                           `FAST_CHARGE_CURRENT_CODE_MAX : wr_data[5:0];
        end
        default: begin
          // Registers outside this bank are accepted and dropped
        end
      endcase
    end
    // Register reset restores all three registers; detection state and the kick pulse are kept
    if (reg_reset) begin
      regs_d[0] = `POR_INPUT_CONTROL;
      regs_d[1] = `POR_POWER_ON_CONFIG;
      regs_d[2] = `POR_CHARGE_CURRENT_CONTROL;
    end
  end

  // Register flops with power-on values
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regs_q[0] <= `POR_INPUT_CONTROL;
      regs_q[1] <= `POR_POWER_ON_CONFIG;
      regs_q[2] <= `POR_CHARGE_CURRENT_CONTROL;
      det_done_q <= 1'b0;
      kick_q <= 1'b0;
    end else begin
      regs_q <= regs_d;
      det_done_q <= det_done_d;
      kick_q <= kick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field decode toward the analog core
  assign input_disconnect_en = regs_q[0][`BIT_DISCONNECT];
  assign high_impedance_state = input_disconnect_en;
  assign status_pin_ctrl = regs_q[0][6:5];
  // Reserved codes leave the pin working; only 11 floats it
  assign status_pin_en = (status_pin_ctrl != `STATUS_PIN_OFF);
  assign input_current_limit = regs_q[0][4:0];
  assign light_load_mode_off = regs_q[1][`BIT_LIGHT_LOAD_OFF];
  assign watchdog_kick = kick_q;
  assign boost_output_en = regs_q[1][`BIT_BOOST_EN];
  assign charge_en_bit = regs_q[1][`BIT_CHARGE_EN];
  assign min_system_voltage = regs_q[1][3:1];
  assign boost_low_batt_sel = regs_q[1][`BIT_LOW_BATT_SEL];
  // Default thresholds; the other setting is a parameter
  assign batt_low_fall_mv = boost_low_batt_sel ? ALT_FALL_MV :
                            `LOW_BATT_FALL_MV;
  assign batt_low_rise_mv = boost_low_batt_sel ? ALT_RISE_MV :
                            `LOW_BATT_RISE_MV;
  assign boost_current_limit = regs_q[2][`BIT_BOOST_LIMIT];
  assign input_switch_full_on = regs_q[2][`BIT_FULL_ON];
  assign fast_charge_current = regs_q[2][5:0];
  // Boost always uses the full switch
  assign high_r_switch_sel = ~boost_output_en & ~input_switch_full_on &
                             (input_current_limit < `IIN_CODE_700MA);
  // Boost wins, pin and bit must agree, zero current stops it
  assign charge_active = charge_en_bit & ~ce_n_s & ~boost_output_en &
    (fast_charge_current != `FAST_CHARGE_CURRENT_CODE_ZERO);

  ////////////////////////////////////////////////////////////////////////
  // Serial slave sequencer
  i2c_state_t st_q, st_d, nxt_q, nxt_d; // State and state after ACK
  logic [3:0] cnt_q, cnt_d; // Bits moved in this byte
  byte_t sh_q, sh_d; // Shift register
  logic oe_q, oe_d; // Pulls data low while set
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  always_comb begin
    st_d = st_q;
    nxt_d = nxt_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    oe_d = oe_q;
    ptr_d = ptr_q;
    wr_en = 1'b0;
    wr_data = sh_q;
    if (bus_stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (bus_start) begin
      // Repeated start keeps the pointer for the read phase
      st_d = ST_DEV;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_DEV, ST_REGADR, ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            st_d = ST_IDLE; // No match: stay silent
            if (st_q == ST_DEV && sh_q[7:1] == SLAVE_ADDR) begin
              oe_d = 1'b1;
              st_d = ST_ACK;
              nxt_d = sh_q[0] ? ST_RDATA : ST_REGADR;
            end else if (st_q == ST_REGADR && sh_q <= `OFS_LAST) begin
              ptr_d = sh_q;
              oe_d = 1'b1;
              st_d = ST_ACK;
              nxt_d = ST_WDATA;
            end else if (st_q == ST_WDATA && ptr_q <= `OFS_LAST) begin
              wr_en = 1'b1;
              ptr_d = ptr_next;
              oe_d = 1'b1;
              st_d = ST_ACK;
              nxt_d = ST_WDATA;
            end
            // Other outcomes fall through as NACK and idle
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            st_d = nxt_q;
            oe_d = 1'b0;
            if (nxt_q == ST_RDATA) begin
              // Present the first bit as the clock goes low
              sh_d = rd_data;
              oe_d = ~rd_data[7];
              cnt_d = 4'h1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == `BITS_PER_BYTE) begin
              oe_d = 1'b0; // Master drives its acknowledge
              st_d = ST_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_d = ST_IDLE; // Master has had enough
            end else begin
              ptr_d = ptr_next;
              st_d = ST_ACK;
              nxt_d = ST_RDATA;
            end
          end
        end
      endcase
    end
  end

  // Sequencer flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      oe_q <= 1'b0;
      ptr_q <= 8'h00;
    end else begin
      st_q <= st_d;
      nxt_q <= nxt_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      oe_q <= oe_d;
      ptr_q <= ptr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_kick_write;
    wr_en && ptr_q == `OFS_POWER_ON_CONFIG && wr_data[`BIT_KICK];
  endsequence
  sequence s_kick_seen;
    watchdog_kick && regs_q[1][`BIT_KICK];
  endsequence

  a_por_input_ctl: assert property (
    !$past(rst_n) |-> regs_q[0] == `POR_INPUT_CONTROL)
    else $error("input control power-on value wrong");
  a_por_config: assert property (
    !$past(rst_n) |-> regs_q[1] == `POR_POWER_ON_CONFIG)
    else $error("power-on config value wrong");
  a_por_charge: assert property (
    !$past(rst_n) |-> regs_q[2] == `POR_CHARGE_CURRENT_CONTROL)
    else $error("charge control power-on value wrong");
  a_kick_write: assert property (
    s_kick_write and !reg_reset |=> s_kick_seen)
    else $error("kick write not seen");
  a_kick_zero: assert property (
    wr_en && ptr_q == `OFS_POWER_ON_CONFIG && !wr_data[`BIT_KICK]
    |=> !watchdog_kick)
    else $error("zero kick pulsed the timer");
  a_kick_clear: assert property (
    wd_timer_cleared && !wr_en |=> !regs_q[1][`BIT_KICK])
    else $error("kick bit not cleared");
  a_wd_keeps: assert property (
    wd_expire && !reg_reset && !wr_en && !src_detect_done
    |=> !regs_q[0][`BIT_DISCONNECT] && $stable(regs_q[0][6:0]))
    else $error("watchdog restore wrong");
  a_iin_detect: assert property (
    src_detect_done && src_sel_s && !reg_reset
    |=> input_current_limit == `IIN_CODE_500MA)
    else $error("detected limit wrong");
  a_fast_charge_current_clamp: assert property (
    fast_charge_current <= `FAST_CHARGE_CURRENT_CODE_MAX)
    else $error("charge current above ceiling");
  a_charge_gate: assert property (
    charge_active |-> charge_en_bit && !ce_n_s && !boost_output_en &&
    fast_charge_current != `FAST_CHARGE_CURRENT_CODE_ZERO)
    else $error("charging without its conditions");
  a_nack_idle: assert property (
    st_q == ST_REGADR && scl_fall && cnt_q == `BITS_PER_BYTE &&
    sh_q > `OFS_LAST && !bus_start && !bus_stop
    |=> st_q == ST_IDLE && !sda_oe)
    else $error("bad register address acknowledged");
  a_ptr_skip: assert property (
    ptr_q == `OFS_FAULT - 8'h01 && wr_en |=> ptr_q == `OFS_AFTER_FAULT)
    else $error("fault register not skipped");
  a_boost_switch: assert property (
    boost_output_en |-> !high_r_switch_sel)
    else $error("high-resistance switch in boost");
endmodule // charger_ctrl_regs

// ### hdl/charger_pkg.sv
// Types shared by the charger register bank.
// Assumes the constants header is included where numbers are needed.
package charger_pkg;
  // Serial slave sequencing
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_REGADR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK
  } i2c_state_t;
  typedef logic [7:0] byte_t;
endpackage

// ### hdl/charger_regs.svh
// Register offsets, reset values, field limits and bus constants for
// the charger control register bank. Assumes an 8-bit register space.
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH
// Bus slave address (7 bits)
`define DEV_ADDR 7'h6b
// Register offsets
`define OFS_INPUT_CONTROL 8'h00
`define OFS_POWER_ON_CONFIG 8'h01
`define OFS_CHARGE_CURRENT_CONTROL 8'h02
`define OFS_FAULT 8'h09
`define OFS_AFTER_FAULT 8'h0a
`define OFS_LAST 8'h0b
// Power-on values
`define POR_INPUT_CONTROL 8'h17
`define POR_POWER_ON_CONFIG 8'h1a
`define POR_CHARGE_CURRENT_CONTROL 8'ha2
// Bits restored by watchdog expiry, per register
`define WD_MASK_INPUT_CONTROL 8'h80
`define WD_MASK_POWER_ON_CONFIG 8'h70
`define WD_MASK_CHARGE_CURRENT_CONTROL 8'hbf
// Read answers
`define RD_UNMAPPED 8'hff
`define RD_NOT_HELD 8'h00
// Field positions
`define BIT_DISCONNECT 7
`define BIT_LIGHT_LOAD_OFF 7
`define BIT_KICK 6
`define BIT_BOOST_EN 5
`define BIT_CHARGE_EN 4
`define BIT_LOW_BATT_SEL 0
`define BIT_BOOST_LIMIT 7
`define BIT_FULL_ON 6
// Field values
`define STATUS_PIN_OFF 2'h3
`define IIN_CODE_500MA 5'h04
`define IIN_CODE_700MA 5'h06
`define FAST_CHARGE_CURRENT_CODE_MAX 6'h32
`define FAST_CHARGE_CURRENT_CODE_ZERO 6'h00
`define LOW_BATT_FALL_MV 12'hb86
`define LOW_BATT_RISE_MV 12'hc4e
// Bit counting on the serial bus
`define BITS_PER_BYTE 4'h8
`endif

// ### hdl/sync_2ff.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level; the output lags by two edges.
`timescale 1ns/1ps
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  // First stage feeds only the second stage
  logic meta_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sync_2ff
